//--- src/char_port_defs.vh
// Purpose: constants for the character display host port
// Assumes: 100 MHz system clock
// Notes: times in ns, cycle counts derived from them
`ifndef CHAR_PORT_DEFS_VH
`define CHAR_PORT_DEFS_VH

`define CLK_PERIOD_NS 10
`define BUSY_TIME_NS 600
`define BUSY_CYCLES ((`BUSY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SET_CHAR_ADDR_BIT 7
`define DRAM_DEPTH 128
`define GLYPH_DEPTH 64
`define LINE_SPLIT 7'h40
`define ADDR_RESET 7'h00
`define DATA_RESET 8'h00
`define INSTR_RESET 8'h00
`define OP_CLEAR 8'h01
`define OP_HOME_MASK 8'hFE
`define OP_HOME 8'h02
`define ENTRY_BIT_DIR 1
`define FUNC_BIT_LINES 3
`define SHIFT_BIT_DISPLAY 3
`define SHIFT_BIT_RIGHT 2
`define GLYPH_SEL_BIT 6

`endif

//--- src/char_ram.v
// Purpose: flip-flop storage for character and glyph memories
// Assumes: one write port, one asynchronous read port
// Notes: depth and width fixed by the instantiating block
`timescale 1ns/1ps

module char_ram #(
  parameter DEPTH = 128,
  parameter AW = 7
) (
  // Clock
  input wire clk_sys,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output wire [7:0] rd_data
);
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule // char_ram

//--- src/char_display_host_port.v
// Purpose: host parallel port of a character display controller
// Assumes: bus pins synchronous to clk_sys; strobe falling edge marks an access, write or read
// Notes: read data is driven while strobe is high and read_write_select high
// Function
// - Select low targets instructions and status; high targets data holding register.
// - Instruction write loads the instruction store and starts an operation.
// - Status read returns busy on bit seven, address pointer below.
// - Data write loads holding register then moves it into selected RAM.
// - Data read returns RAM contents fetched into the holding register.
// - Instruction store is write only; its read path returns status.
// - While busy, busy reads one and new instructions are ignored.
// - When idle, busy reads zero and the next instruction is taken.
// - Address instruction loads pointer and records glyph or character space.
// - Each data access steps the pointer by one in entry direction.
// - Character RAM holds 128 bytes.
// - Pointer is seven bits wide, bit six down to zero.
// - One-line mode maps positions 0..127 to addresses 00..7F.
// - Two-line mode gives each line 64 bytes, 00..3F and 40..7F.
// - Display shift moves shown addresses by one, wrapping within each line.
`timescale 1ns/1ps
`include "char_port_defs.vh"

module char_display_host_port (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Host bus
  input wire register_select,
  input wire read_write_select,
  input wire bus_strobe,
  input wire [7:0] bus_in,
  output reg [7:0] bus_out,
  output wire bus_oe,
  // Screen position query
  input wire [6:0] screen_pos,
  input wire screen_line,
  output reg [6:0] shown_addr,
  // Status
  output wire busy_indicator,
  output reg line_count_select,
  output reg [6:0] display_offset
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_BUSY = 2'd1;
  localparam ST_FETCH = 2'd2;
  // Wide copy so the counter load is cut to width on purpose
  localparam [31:0] BUSY_WIDE = `BUSY_CYCLES;

  reg [1:0] state;
  reg strobe_q;
  reg [7:0] instruction_store;
  reg [7:0] data_holding_register;
  reg [6:0] address_pointer;
  reg glyph_space;
  reg entry_inc;
  reg [9:0] busy_cnt;
  reg [1:0] next_state;
  reg [9:0] next_busy_cnt;
  reg [7:0] next_instr;
  reg [6:0] next_pointer;
  reg next_glyph_space;
  reg next_entry_inc;
  reg next_lines;
  reg [6:0] next_offset;
  wire host_take;
  wire take_instr;
  wire take_data_wr;
  wire take_data_rd;
  wire cmd_char_addr;
  wire cmd_glyph_addr;
  wire cmd_clear;
  wire cmd_home;
  wire cmd_function;
  wire cmd_shift;
  wire cmd_entry;
  wire [6:0] stepped_pointer;
  reg ram_wr;
  reg [7:0] next_data;
  wire [7:0] char_rd;
  wire [7:0] glyph_rd;
  wire strobe_fall;

  // Wraps an address within its line when two_line is set; stepped_pointer passes 0
  function [6:0] wrap_step;
    input [6:0] a;
    input up;
    input two_line;
    reg [6:0] r;
    begin
      r = up ? a + 7'h01 : a - 7'h01;
      if (two_line) begin
        r = {a[6], r[5:0]};
      end
      wrap_step = r;
    end
  endfunction

  assign strobe_fall = strobe_q & ~bus_strobe;
  assign busy_indicator = (state != ST_IDLE);
  assign bus_oe = bus_strobe & read_write_select;

  // ----------------------------------------------------------------
  // Host cycle decode
  // ----------------------------------------------------------------
  // Only an idle port takes a cycle; strobes while busy vanish silently
  assign host_take = strobe_fall & (state == ST_IDLE);
  assign take_instr = host_take & ~register_select & ~read_write_select;
  assign take_data_wr = host_take & register_select & ~read_write_select;
  assign take_data_rd = host_take & register_select & read_write_select;
  // Flat decode; codes matching none of these are accepted as no-ops
  assign cmd_char_addr = bus_in[`SET_CHAR_ADDR_BIT];
  assign cmd_glyph_addr = (bus_in[7:6] == 2'h1);
  assign cmd_clear = (bus_in == `OP_CLEAR);
  assign cmd_home = ((bus_in & `OP_HOME_MASK) == `OP_HOME);
  assign cmd_function = (bus_in[7:5] == 3'h1);
  assign cmd_shift = (bus_in[7:4] == 4'h1) & bus_in[`SHIFT_BIT_DISPLAY];
  assign cmd_entry = (bus_in[7:2] == 6'h01);
  assign stepped_pointer = wrap_step(address_pointer, entry_inc, 1'b0);

  // ----------------------------------------------------------------
  // Memories
  // ----------------------------------------------------------------
  char_ram #(.DEPTH(`DRAM_DEPTH), .AW(7)) u_char (
    .clk_sys(clk_sys),
    .wr_en(ram_wr & ~glyph_space),
    .wr_addr(address_pointer),
    .wr_data(data_holding_register),
    .rd_addr(address_pointer),
    .rd_data(char_rd)
  );

  char_ram #(.DEPTH(`GLYPH_DEPTH), .AW(6)) u_glyph (
    .clk_sys(clk_sys),
    .wr_en(ram_wr & glyph_space),
    .wr_addr(address_pointer[5:0]),
    .wr_data(data_holding_register),
    .rd_addr(address_pointer[5:0]),
    .rd_data(glyph_rd)
  );

  // ----------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_out <= `DATA_RESET;
    end else if (!register_select) begin
      bus_out <= {busy_indicator, address_pointer};
    end else begin
      bus_out <= data_holding_register;
    end
  end

  // ----------------------------------------------------------------
  // Screen mapping, one position per query
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      shown_addr <= `ADDR_RESET;
    end else if (line_count_select) begin
      // Low six bits wrap within the line picked by screen_line
      shown_addr <= {screen_line, screen_pos[5:0] + display_offset[5:0]};
    end else begin
      shown_addr <= screen_pos + display_offset;
    end
  end

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always @* begin
    next_data = data_holding_register;
    if (take_data_wr) begin
      next_data = bus_in;
    end else if (state == ST_FETCH) begin
      next_data = glyph_space ? glyph_rd : char_rd;
    end
  end

  // ----------------------------------------------------------------
  // Instruction effects
  // ----------------------------------------------------------------
  always @* begin
    next_instr = instruction_store;
    next_pointer = address_pointer;
    next_glyph_space = glyph_space;
    next_entry_inc = entry_inc;
    next_lines = line_count_select;
    next_offset = display_offset;
    if (take_instr) begin
      next_instr = bus_in;
      if (cmd_char_addr) begin
        next_pointer = bus_in[6:0];
        next_glyph_space = 1'b0;
      end else if (cmd_glyph_addr) begin
        next_pointer = {1'b0, bus_in[5:0]};
        next_glyph_space = 1'b1;
      end else if (cmd_clear) begin
        next_pointer = `ADDR_RESET;
        next_offset = 7'h00;
        next_entry_inc = 1'b1;
      end else if (cmd_home) begin
        next_pointer = `ADDR_RESET;
        next_offset = 7'h00;
      end else if (cmd_function) begin
        next_lines = bus_in[`FUNC_BIT_LINES];
      end else if (cmd_shift) begin
        // Left shift shows address plus one
        next_offset = bus_in[`SHIFT_BIT_RIGHT] ? display_offset - 7'h01 : display_offset + 7'h01;
      end else if (cmd_entry) begin
        next_entry_inc = bus_in[`ENTRY_BIT_DIR];
      end
    end else if (state == ST_FETCH || (state == ST_BUSY && ram_wr)) begin
      // Step after the RAM access so a write lands at the old address
      next_pointer = stepped_pointer;
    end
  end

  // ----------------------------------------------------------------
  // Busy sequencing
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    next_busy_cnt = busy_cnt;
    case (state)
      ST_IDLE: begin
        // Status reads with a strobe start nothing
        if (take_instr || take_data_wr) begin
          next_state = ST_BUSY;
          next_busy_cnt = BUSY_WIDE[9:0];
        end else if (take_data_rd) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Fetch lands now; the host sees it on its next read
        next_state = ST_BUSY;
        next_busy_cnt = BUSY_WIDE[9:0];
      end
      ST_BUSY: begin
        if (busy_cnt <= 10'h001) begin
          next_state = ST_IDLE;
        end else begin
          next_busy_cnt = busy_cnt - 10'h001;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Port sequencing registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
      state <= ST_IDLE;
      busy_cnt <= 10'h000;
      ram_wr <= 1'b0;
    end else begin
      strobe_q <= bus_strobe;
      state <= next_state;
      busy_cnt <= next_busy_cnt;
      // Write pulse lags the take so the held byte is settled first
      ram_wr <= take_data_wr;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      instruction_store <= `INSTR_RESET;
      data_holding_register <= `DATA_RESET;
      address_pointer <= `ADDR_RESET;
      glyph_space <= 1'b0;
      entry_inc <= 1'b1;
      line_count_select <= 1'b0;
      display_offset <= 7'h00;
    end else begin
      instruction_store <= next_instr;
      data_holding_register <= next_data;
      address_pointer <= next_pointer;
      glyph_space <= next_glyph_space;
      entry_inc <= next_entry_inc;
      line_count_select <= next_lines;
      display_offset <= next_offset;
    end
  end
endmodule // char_display_host_port

//--- verification/char_port_assertions.sv
// Purpose: port checks for char_display_host_port
// Assumes: busy length from the shared header
// Notes: bound after the module
`timescale 1ns/1ps
`include "char_port_defs.vh"
module char_port_checker (
  // Clock, reset, host bus
  input wire clk_sys,
  input wire rst_n,
  input wire register_select,
  input wire read_write_select,
  input wire bus_strobe,
  input wire [7:0] bus_out,
  input wire bus_oe,
  // Screen and status
  input wire [6:0] screen_pos,
  input wire screen_line,
  input wire [6:0] shown_addr,
  input wire busy_indicator,
  input wire line_count_select,
  input wire [6:0] display_offset
);
  reg strobe_q;
  reg [7:0] busy_len;
  reg [5:0] low_sum;
  wire taken = !bus_strobe && strobe_q && !busy_indicator;
  always @(posedge clk_sys) begin
    strobe_q <= rst_n && bus_strobe;
    busy_len <= (rst_n && busy_indicator) ? busy_len + 8'h01 : 8'h00;
    low_sum <= screen_pos[5:0] + display_offset[5:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  oe_follow_a: assert property (bus_oe == (bus_strobe && read_write_select)) else $error("oe wrong");
  busy_start_a: assert property (taken && !(read_write_select && !register_select) |=> busy_indicator)
    else $error("no busy");
  rise_cause_a: assert property ($rose(busy_indicator) |-> $past(taken)) else $error("busy cause");
  idle_stay_a: assert property (!busy_indicator && !taken |=> !busy_indicator) else $error("idle");
  busy_span_a: assert property ($fell(busy_indicator) |-> busy_len == `BUSY_CYCLES ||
    busy_len == `BUSY_CYCLES + 1) else $error("busy length");
  status_bit_a: assert property (!$past(register_select) && $past(rst_n)
    |-> bus_out[7] == $past(busy_indicator)) else $error("status bit");
  line_one_a: assert property (!$past(line_count_select) && $past(rst_n)
    |-> shown_addr == $past(screen_pos) + $past(display_offset)) else $error("one line");
  line_two_a: assert property ($past(line_count_select) && $past(rst_n)
    |-> shown_addr == {$past(screen_line), low_sum}) else $error("two line");
  cover property (taken && register_select && read_write_select);
  cover property (line_count_select && display_offset != 7'h00);
  cover property ($fell(busy_indicator));
endmodule // char_port_checker
bind char_display_host_port char_port_checker u_char_port_checker (.clk_sys(clk_sys), .rst_n(rst_n),
  .register_select(register_select), .read_write_select(read_write_select), .bus_strobe(bus_strobe),
  .bus_out(bus_out), .bus_oe(bus_oe), .screen_pos(screen_pos), .screen_line(screen_line),
  .shown_addr(shown_addr), .busy_indicator(busy_indicator), .line_count_select(line_count_select),
  .display_offset(display_offset));

//--- verification/host_bus_model.sv
// Purpose: host processor model for the display port
// Assumes: strobe high one cycle, low the next
// Notes: bus_in inverted after use, as a released bus
`timescale 1ns/1ps
module host_bus_model (
  // Clock and read back
  input wire clk_sys,
  input wire [7:0] bus_out,
  // Host bus
  output reg register_select = 1'b0,
  output reg read_write_select = 1'b1,
  output reg bus_strobe = 1'b0,
  output reg [7:0] bus_in = 8'h00
);
  task access(input rs, input rw, input [7:0] d);
    begin
      @(posedge clk_sys);
      register_select <= rs;
      read_write_select <= rw;
      bus_in <= d;
      bus_strobe <= 1'b1;
      @(posedge clk_sys);
      bus_strobe <= 1'b0;
      @(posedge clk_sys);
      bus_in <= ~d;
    end
  endtask
  task peek(input rs, output [7:0] v);
    begin
      @(posedge clk_sys);
      register_select <= rs;
      read_write_select <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 v = bus_out;
    end
  endtask
  // Bounded poll; caller judges the last status
  task wait_idle(output [7:0] v);
    integer n;
    begin
      v = 8'hFF;
      for (n = 0; n < 40 && v[7] !== 1'b0; n = n + 1)
        peek(1'b0, v);
    end
  endtask
endmodule // host_bus_model

//--- verification/char_display_host_port_bench.sv
// Purpose: self-checking bench for char_display_host_port
// Assumes: busy length from the shared header
// Notes: scenarios run back to back; reset at start and again in t_reset
`timescale 1ns/1ps
module char_display_host_port_bench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [6:0] screen_pos = 7'h00;
  reg screen_line = 1'b0;
  wire register_select, read_write_select, bus_strobe, bus_oe, busy_indicator, line_count_select;
  wire [7:0] bus_in, bus_out;
  wire [6:0] shown_addr, display_offset;
  reg [7:0] v;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  always #5 clk_sys = ~clk_sys;
  char_display_host_port u_char_display_host_port (.clk_sys(clk_sys), .rst_n(rst_n),
    .register_select(register_select), .read_write_select(read_write_select), .bus_strobe(bus_strobe),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .screen_pos(screen_pos), .screen_line(screen_line),
    .shown_addr(shown_addr), .busy_indicator(busy_indicator), .line_count_select(line_count_select),
    .display_offset(display_offset));
  host_bus_model u_host_bus_model (.clk_sys(clk_sys), .bus_out(bus_out), .register_select(register_select),
    .read_write_select(read_write_select), .bus_strobe(bus_strobe), .bus_in(bus_in));
  task check(input string what, input logic [7:0] seen, input logic [7:0] expected);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== expected) begin
        num_errors = num_errors + 1;
        $display("[ERR] %s expected %h seen %h", what, expected, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task op(input rs, input rw, input [7:0] d, input [7:0] expected);
    begin
      u_host_bus_model.access(rs, rw, d);
      u_host_bus_model.wait_idle(v);
      check("status", v, expected);
    end
  endtask
  task show(input line, input [6:0] pos, input [6:0] expected);
    begin
      @(posedge clk_sys);
      screen_line <= line;
      screen_pos <= pos;
      repeat (2) @(posedge clk_sys);
      #1 check("shown", {1'b0, shown_addr}, {1'b0, expected});
    end
  endtask
  task t_access;
    begin
      u_host_bus_model.peek(1'b0, v);
      check("reset status", v, 8'h00);
      u_host_bus_model.access(1'b0, 1'b0, 8'h85);
      u_host_bus_model.peek(1'b0, v);
      check("busy", {7'h00, v[7]}, 8'h01);
      u_host_bus_model.wait_idle(v);
      check("pointer", v, 8'h05);
      u_host_bus_model.access(1'b1, 1'b0, 8'hA5);
      op(1'b0, 1'b0, 8'h90, 8'h06);
      op(1'b0, 1'b0, 8'h85, 8'h05);
      op(1'b1, 1'b1, 8'h00, 8'h06);
      u_host_bus_model.peek(1'b1, v);
      check("data", v, 8'hA5);
    end
  endtask
  task t_screen;
    begin
      op(1'b0, 1'b0, 8'h38, 8'h06);
      check("lines", {7'h00, line_count_select}, 8'h01);
      show(1'b1, 7'h03, 7'h43);
      op(1'b0, 1'b0, 8'h18, 8'h06);
      show(1'b1, 7'h3F, 7'h40);
      op(1'b0, 1'b0, 8'h1C, 8'h06);
      op(1'b0, 1'b0, 8'h1C, 8'h06);
      show(1'b0, 7'h00, 7'h3F);
      op(1'b0, 1'b0, 8'h30, 8'h06);
      show(1'b0, 7'h00, 7'h7F);
    end
  endtask
  task t_glyph;
    begin
      op(1'b0, 1'b0, 8'h04, 8'h06);
      op(1'b0, 1'b0, 8'h4A, 8'h0A);
      op(1'b1, 1'b0, 8'h3C, 8'h09);
      op(1'b0, 1'b0, 8'h4A, 8'h0A);
      op(1'b1, 1'b1, 8'h00, 8'h09);
      u_host_bus_model.access(1'b0, 1'b0, 8'h85);
      u_host_bus_model.access(1'b1, 1'b0, 8'h77);
      u_host_bus_model.wait_idle(v);
      check("refused", v, 8'h05);
      u_host_bus_model.peek(1'b1, v);
      check("glyph data", v, 8'h3C);
      op(1'b0, 1'b0, 8'h01, 8'h00);
      check("offset", {1'b0, display_offset}, 8'h00);
    end
  endtask
  task t_reset;
    begin
      op(1'b0, 1'b0, 8'h38, 8'h00);
      op(1'b0, 1'b0, 8'h9B, 8'h1B);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      u_host_bus_model.peek(1'b0, v);
      check("status after reset", v, 8'h00);
      check("lines after reset", {7'h00, line_count_select}, 8'h00);
      op(1'b0, 1'b0, 8'h8C, 8'h0C);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_access;
    t_screen;
    t_glyph;
    t_reset;
    conclude;
  end
  // Cut a hang short well past the longest expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end
endmodule // char_display_host_port_bench
